/* rtl/bcir_defs.vh */
// Constants for the board command and information register group.
`ifndef BCIR_DEFS_VH
`define BCIR_DEFS_VH

`define BCIR_ADDR_W              32
`define BCIR_DATA_W              32
`define BCIR_REG_BOARD_COMMAND   32'h0000_0000
`define BCIR_REG_DRV_LIB_VER     32'h0000_04b0
`define BCIR_REG_KERNEL_VER      32'h0000_04ba
`define BCIR_REG_DRIVER_KIND     32'h0000_04c4
`define BCIR_REG_IRQ_LINE        32'h0000_08fc

`define BCIR_CMD_FULL_RESET      32'h0000_0000
`define BCIR_CMD_ENTER_LOW_POWER 32'h0000_001e
`define BCIR_CMD_RESET_VALUE     32'h0000_0000

`define BCIR_KIND_W              3
`define BCIR_KIND_UNIX_32        3'h1
`define BCIR_KIND_WIN_32         3'h4
`define BCIR_KIND_WIN_64         3'h5
`define BCIR_KIND_WIN_32_ON_64   3'h6
`define BCIR_KIND_UNIX_64        3'h7

`define BCIR_ZERO_DATA           32'h0000_0000

`define BCIR_RO_COUNT            4
`define BCIR_FLAG_OFF            1'h0
`define BCIR_FLAG_ON             1'h1

`endif

/* rtl/bcir_board_regs.v */
// Board command and information register group with power state control.
`timescale 1ns/100ps
`default_nettype none
`include "bcir_defs.vh"

module bcir_board_regs (
    input  wire                      clk_i,
    input  wire                      reset_i,
    input  wire                      reg_write_i,
    input  wire                      reg_read_i,
    input  wire [`BCIR_ADDR_W-1:0]   reg_addr_i,
    input  wire [`BCIR_DATA_W-1:0]   reg_wdata_i,
    output reg  [`BCIR_DATA_W-1:0]   reg_rdata_o,
    output reg                       reg_rvalid_o,
    input  wire                      run_start_i,
    input  wire                      mem_filled_i,
    input  wire [`BCIR_DATA_W-1:0]   irq_line_i,
    input  wire [`BCIR_KIND_W-1:0]   driver_kind_i,
    input  wire [`BCIR_DATA_W-1:0]   drv_lib_version_i,
    input  wire [`BCIR_DATA_W-1:0]   kernel_version_i,
    output reg                       low_power_o,
    output reg                       mem_valid_o,
    output reg                       config_reset_o
);

    // Power state codes, one-hot; the default branch of the state machine
    // steers an illegal code back to normal operation.
    localparam [1:0] PWR_NORMAL = 2'h1;
    localparam [1:0] PWR_LOW    = 2'h2;

    // Compares an address against one register offset. The command register
    // and every read-only word share it, so all decoders match the same way.
    function bcir_addr_match;
        input [`BCIR_ADDR_W-1:0] addr;
        input [`BCIR_ADDR_W-1:0] target;
        begin
            bcir_addr_match = (addr == target);
        end
    endfunction

    reg  [`BCIR_DATA_W-1:0]                    board_command;
    reg  [1:0]                                 power_state;
    reg  [1:0]                                 next_power_state;
    reg                                        next_mem_valid;
    reg                                        next_low_power;
    reg                                        next_config_reset;
    reg                                        next_rvalid;
    reg  [`BCIR_DATA_W-1:0]                    next_rdata;

    wire [`BCIR_RO_COUNT*`BCIR_ADDR_W-1:0]     ro_addr_flat;
    wire [`BCIR_RO_COUNT*`BCIR_DATA_W-1:0]     ro_word_flat;
    wire [`BCIR_RO_COUNT-1:0]                  ro_hit;
    wire [(`BCIR_RO_COUNT+1)*`BCIR_DATA_W-1:0] ro_chain;
    wire [`BCIR_DATA_W-1:0]                    ro_data;
    wire [`BCIR_DATA_W-1:0]                    kind_word;

    wire                                       cmd_hit;
    wire                                       cmd_write;
    wire                                       do_reset;
    wire                                       do_sleep;
    wire                                       in_low_power;
    wire                                       fill_allowed;

    assign cmd_hit      = bcir_addr_match(reg_addr_i, `BCIR_REG_BOARD_COMMAND);
    assign cmd_write    = reg_write_i && cmd_hit;
    assign do_reset     = cmd_write && (reg_wdata_i == `BCIR_CMD_FULL_RESET);
    assign do_sleep     = cmd_write && (reg_wdata_i == `BCIR_CMD_ENTER_LOW_POWER);
    assign in_low_power = (power_state == PWR_LOW);
    assign fill_allowed = mem_filled_i && !in_low_power;

    // The driver kind is three bits wide; the upper bits of its word read zero.
    assign kind_word = {{(`BCIR_DATA_W-`BCIR_KIND_W){`BCIR_FLAG_OFF}}, driver_kind_i};

    // Read-only word table; index 0 sits in the lowest bits.
    assign ro_addr_flat = {`BCIR_REG_KERNEL_VER,
                           `BCIR_REG_DRV_LIB_VER,
                           `BCIR_REG_DRIVER_KIND,
                           `BCIR_REG_IRQ_LINE};
    assign ro_word_flat = {kernel_version_i,
                           drv_lib_version_i,
                           kind_word,
                           irq_line_i};

    assign ro_chain[`BCIR_DATA_W-1:0] = `BCIR_ZERO_DATA;

    // Each word gates itself onto an OR chain. The offsets are distinct, so at
    // most one word survives; an unmapped address leaves the chain at zero.
    genvar gi;
    generate
        for (gi = 0; gi < `BCIR_RO_COUNT; gi = gi + 1) begin : g_ro_word
            wire [`BCIR_DATA_W-1:0] gated_word;
            assign ro_hit[gi] = bcir_addr_match(reg_addr_i,
                                                ro_addr_flat[gi*`BCIR_ADDR_W +: `BCIR_ADDR_W]);
            assign gated_word = ro_word_flat[gi*`BCIR_DATA_W +: `BCIR_DATA_W] &
                                {`BCIR_DATA_W{ro_hit[gi]}};
            assign ro_chain[(gi+1)*`BCIR_DATA_W +: `BCIR_DATA_W] =
                ro_chain[gi*`BCIR_DATA_W +: `BCIR_DATA_W] | gated_word;
        end
    endgenerate

    assign ro_data = ro_chain[`BCIR_RO_COUNT*`BCIR_DATA_W +: `BCIR_DATA_W];

    // Next power state. A reset command wins, then a power-down command, then
    // a run start.
    always @* begin
        next_power_state = power_state;
        case (power_state)
            PWR_NORMAL: begin
                if (do_sleep) begin
                    next_power_state = PWR_LOW;
                end else begin
                    next_power_state = PWR_NORMAL;
                end
            end
            PWR_LOW: begin
                if (do_reset) begin
                    next_power_state = PWR_NORMAL;
                end else if (do_sleep) begin
                    next_power_state = PWR_LOW;
                end else if (run_start_i) begin
                    // A run start wakes the board; memory stays invalid until
                    // the sample loader outside marks fresh data.
                    next_power_state = PWR_NORMAL;
                end else begin
                    next_power_state = PWR_LOW;
                end
            end
            default: begin
                next_power_state = PWR_NORMAL;
            end
        endcase
    end

    // Sample memory validity. An invalidating command beats a fill flagged in
    // the same cycle, because the command destroys what the fill just marked.
    // Fills are ignored in the low-power state, where nothing in memory may be
    // read back or replayed.
    always @* begin
        next_mem_valid = mem_valid_o;
        if (do_reset) begin
            next_mem_valid = `BCIR_FLAG_OFF;
        end else if (do_sleep) begin
            next_mem_valid = `BCIR_FLAG_OFF;
        end else if (fill_allowed) begin
            next_mem_valid = `BCIR_FLAG_ON;
        end else begin
            next_mem_valid = mem_valid_o;
        end
    end

    always @* begin
        next_low_power    = `BCIR_FLAG_OFF;
        next_config_reset = `BCIR_FLAG_OFF;
        if (next_power_state == PWR_LOW) begin
            next_low_power = `BCIR_FLAG_ON;
        end
        if (do_reset) begin
            next_config_reset = `BCIR_FLAG_ON;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_state <= PWR_NORMAL;
        end else begin
            power_state <= next_power_state;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_power_o <= `BCIR_FLAG_OFF;
        end else begin
            low_power_o <= next_low_power;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_valid_o <= `BCIR_FLAG_OFF;
        end else begin
            mem_valid_o <= next_mem_valid;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            config_reset_o <= `BCIR_FLAG_OFF;
        end else begin
            config_reset_o <= next_config_reset;
        end
    end

    // Any code written to the command register is kept for read-back; only
    // the two defined codes have side effects.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            board_command <= `BCIR_CMD_RESET_VALUE;
        end else if (cmd_write) begin
            board_command <= reg_wdata_i;
        end
    end

    always @* begin
        next_rdata  = `BCIR_ZERO_DATA;
        next_rvalid = reg_read_i;
        if (cmd_hit) begin
            next_rdata = board_command;
        end else begin
            next_rdata = ro_data;
        end
    end

    // Read data holds until the next read, so a slow host may still pick it
    // up after the valid pulse has gone.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= `BCIR_ZERO_DATA;
        end else if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rvalid_o <= `BCIR_FLAG_OFF;
        end else begin
            reg_rvalid_o <= next_rvalid;
        end
    end

endmodule // bcir_board_regs
`default_nettype wire

/* tb/bcir_host.sv */
// Host model issuing one register access per call.
`timescale 1ns/100ps
`default_nettype none
module bcir_host (
    input  wire logic        clk_i,
    output logic             we_o,
    output logic             re_o,
    output logic [31:0]      a_o,
    output logic [31:0]      d_o
);
    initial begin
        we_o = 1'h0;
        re_o = 1'h0;
        a_o  = 32'h0;
        d_o  = 32'h0;
    end
    // Strobe, address and data stand from one falling edge to the next, so
    // the block takes them at the single rising edge in between.
    task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] dt);
        @(negedge clk_i);
        we_o = w;
        re_o = !w;
        a_o  = ad;
        d_o  = dt;
        @(negedge clk_i);
        we_o = 1'h0;
        re_o = 1'h0;
    endtask
endmodule // bcir_host
`default_nettype wire

/* tb/bcir_checker.sv */
// Port assertions for the board register group.
`timescale 1ns/100ps
`default_nettype none
module bcir_checker (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic        reg_rvalid_o,
    input  wire logic        run_start_i,
    input  wire logic        mem_filled_i,
    input  wire logic [31:0] irq_line_i,
    input  wire logic [2:0]  driver_kind_i,
    input  wire logic [31:0] drv_lib_version_i,
    input  wire logic [31:0] kernel_version_i,
    input  wire logic        low_power_o,
    input  wire logic        mem_valid_o,
    input  wire logic        config_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic cmd     = reg_write_i && reg_addr_i == 32'h0;
    wire logic pd      = cmd && reg_wdata_i == 32'h1e;
    wire logic rst_cmd = cmd && reg_wdata_i == 32'h0;
    chk_read_valid: assert property (reg_read_i |=> reg_rvalid_o)
        else $error("read valid missing");
    chk_valid_cause: assert property (reg_rvalid_o |-> $past(reg_read_i))
        else $error("read valid without a read");
    chk_enter_low: assert property (pd |=> low_power_o && !mem_valid_o)
        else $error("power down");
    chk_low_cause: assert property ($rose(low_power_o) |-> $past(pd))
        else $error("low power without its code");
    chk_low_no_data: assert property (low_power_o |-> !mem_valid_o)
        else $error("memory valid in low power");
    chk_reset_cmd: assert property (rst_cmd |=>
        !low_power_o && config_reset_o && !mem_valid_o) else $error("reset code");
    chk_cfg_cause: assert property (config_reset_o |-> $past(rst_cmd))
        else $error("config reset without its code");
    chk_run_wake: assert property (run_start_i && !pd |=> !low_power_o)
        else $error("wake");
    chk_other_code: assert property (cmd && !rst_cmd && !pd && !run_start_i && !mem_filled_i
        |=> $stable(low_power_o) && $stable(mem_valid_o) && !config_reset_o)
        else $error("other code");
    chk_fill_sets: assert property (mem_filled_i && !low_power_o && !rst_cmd && !pd
        |=> mem_valid_o) else $error("fill not taken");
    chk_kind_read: assert property (reg_read_i && reg_addr_i == 32'h4c4 |=>
        reg_rdata_o == {29'h0, $past(driver_kind_i)}) else $error("kind");
    chk_irq_read: assert property (reg_read_i && reg_addr_i == 32'h8fc |=>
        reg_rdata_o == $past(irq_line_i)) else $error("irq line");
    chk_lib_read: assert property (reg_read_i && reg_addr_i == 32'h4b0 |=>
        reg_rdata_o == $past(drv_lib_version_i)) else $error("library version");
    chk_kernel_read: assert property (reg_read_i && reg_addr_i == 32'h4ba |=>
        reg_rdata_o == $past(kernel_version_i)) else $error("kernel version");
endmodule // bcir_checker
bind bcir_board_regs bcir_checker bcir_checker_inst (.*);
`default_nettype wire

/* tb/tb_bcir_board_regs.sv */
// Self-checking bench for the board register group.
`timescale 1ns/100ps
`default_nettype none
module tb_bcir_board_regs;
    logic        clk_i        = 1'h0;
    logic        reset_i      = 1'h1;
    logic        run_start_i  = 1'h0;
    logic        mem_filled_i = 1'h0;
    logic        we;
    logic        re;
    logic        rv;
    logic        lp;
    logic        mv;
    logic        cr;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic [31:0] irq_line     = 32'hb;
    logic [31:0] lib_ver      = 32'h10203;
    logic [31:0] kern_ver     = 32'h40506;
    logic [2:0]  k            = 3'h0;
    int          n_errors     = 0;
    int          checks_done  = 0;
    always #12.5 clk_i = ~clk_i;
    bcir_host bcir_host_inst (
        .clk_i (clk_i),
        .we_o  (we),
        .re_o  (re),
        .a_o   (a),
        .d_o   (d)
    );
    bcir_board_regs bcir_board_regs_inst (
        .clk_i             (clk_i),
        .reset_i           (reset_i),
        .reg_write_i       (we),
        .reg_read_i        (re),
        .reg_addr_i        (a),
        .reg_wdata_i       (d),
        .reg_rdata_o       (rd),
        .reg_rvalid_o      (rv),
        .run_start_i       (run_start_i),
        .mem_filled_i      (mem_filled_i),
        .irq_line_i        (irq_line),
        .driver_kind_i     (k),
        .drv_lib_version_i (lib_ver),
        .kernel_version_i  (kern_ver),
        .low_power_o       (lp),
        .mem_valid_o       (mv),
        .config_reset_o    (cr)
    );
    task cmp_word(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task cmp_flag(input string n, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %b got %b", n, e, s);
        end
    endtask
    task rdc(input logic [31:0] ad, input logic [31:0] e);
        bcir_host_inst.acc(1'h0, ad, 32'h0);
        cmp_flag("rvalid", 1'h1, rv);
        cmp_word("rdata", e, rd);
    endtask
    task wr(input logic [31:0] ad, input logic [31:0] dt);
        bcir_host_inst.acc(1'h1, ad, dt);
    endtask
    task pulse_run;
        @(negedge clk_i);
        run_start_i = 1'h1;
        @(negedge clk_i);
        run_start_i = 1'h0;
    endtask
    task fill;
        @(negedge clk_i);
        mem_filled_i = 1'h1;
        @(negedge clk_i);
        mem_filled_i = 1'h0;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        reset_i = 1'h0;
        cmp_flag("low", 1'h0, lp); cmp_flag("mem", 1'h0, mv); cmp_flag("cfg", 1'h0, cr);
        rdc(32'h8fc, 32'hb);
        @(negedge clk_i); cmp_flag("rvalid", 1'h0, rv);
        irq_line = 32'h5; rdc(32'h8fc, 32'h5);
        rdc(32'h4b0, 32'h10203);
        rdc(32'h4ba, 32'h40506);
        lib_ver = 32'h30201; kern_ver = 32'h60504;
        rdc(32'h4b0, 32'h30201);
        rdc(32'h4ba, 32'h60504);
        rdc(32'h10, 32'h0);
        $display("identity test done");
        for (int i = 0; i < 8; i++) begin k = i[2:0]; rdc(32'h4c4, i); end
        wr(32'h4c4, 32'h2); rdc(32'h4c4, 32'h7);
        $display("kind test done");
        fill; cmp_flag("mem", 1'h1, mv);
        wr(32'h0, 32'h1e); cmp_flag("low", 1'h1, lp); cmp_flag("mem", 1'h0, mv);
        fill; cmp_flag("mem", 1'h0, mv); rdc(32'h0, 32'h1e);
        pulse_run; cmp_flag("low", 1'h0, lp); cmp_flag("mem", 1'h0, mv);
        fill; cmp_flag("mem", 1'h1, mv);
        wr(32'h0, 32'h1e); wr(32'h0, 32'h5);
        cmp_flag("low", 1'h1, lp); cmp_flag("cfg", 1'h0, cr); rdc(32'h0, 32'h5);
        wr(32'h0, 32'h0); cmp_flag("cfg", 1'h1, cr); cmp_flag("low", 1'h0, lp);
        @(negedge clk_i); cmp_flag("cfg", 1'h0, cr);
        fill; wr(32'h0, 32'h7); cmp_flag("mem", 1'h1, mv); cmp_flag("low", 1'h0, lp);
        cmp_flag("cfg", 1'h0, cr);
        wr(32'h0, 32'h0); cmp_flag("mem", 1'h0, mv); cmp_flag("cfg", 1'h1, cr);
        $display("command test done");
        wr(32'h0, 32'h1e); wr(32'h0, 32'h9);
        @(negedge clk_i); reset_i = 1'h1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'h0;
        cmp_flag("low", 1'h0, lp); cmp_flag("mem", 1'h0, mv); cmp_flag("rvalid", 1'h0, rv);
        rdc(32'h0, 32'h0);
        $display("mid-run reset test done");
        give_verdict;
    end
endmodule // tb_bcir_board_regs
`default_nettype wire
